/* File: rtl/fcr_device.sv */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Host sends lock byte bits 7-2 zero.
// - Flag status read accepted any time.
// - Flag status byte repeats while selected.
// - Host polls ready flag after self-timed write.
// - Clear flag status resets four error flags.
// - Clear flag status ignores and keeps latch.
// - Configuration writes need write-enable latch set, volatile ones only outside fast power-on state.
// - Nonvolatile write needs exactly sixteen data bits.
// - Nonvolatile write starts self-timed cycle.
// - Busy shows in status and flag status.
// - Self-timed cycle end clears write-enable latch.
// - Nonvolatile values apply after next power-on.
// - Fast power-on state skips write-enable need for volatile and enhanced volatile writes only.
// - Volatile write needs exactly eight data bits.
// - Enhanced volatile write needs exactly eight bits.
// - Volatile writes clear latch, no timed cycle.
// - Volatile values apply at once.
// - Read commands shift out current register contents.
// - Lock write: address, one byte, latch.
// - Suspend never pauses nonvolatile write cycle.
module fcr_device #(
  parameter int NUM_SECTORS     = 256,
  parameter int NV_WRITE_CYCLES = fcr_pkg::NVCR_WRITE_CYCLES
) (
  // Clock and reset
  input  wire logic                REF_CLK,
  input  wire logic                RESET_N,
  // Serial link
  fcr_spi_if.dev                   SPI,
  // Array side
  input  wire logic                ARRAY_BUSY,
  input  wire logic [3:0]          ERR_SET,
  input  wire logic                FAST_POR_STRAP,
  input  wire logic                NV_INIT_N,
  output logic                     SUSPEND_REQ,
  // Configuration outputs
  output logic [15:0]              NV_CONFIG_ACTIVE,
  output logic [15:0]              NV_CONFIG_STORED,
  output fcr_pkg::fcr_byte_t       VOL_CONFIG,
  output fcr_pkg::fcr_byte_t       EVOL_CONFIG,
  output logic                     WRITE_ENABLE_LATCH,
  output logic                     WRITE_IN_PROGRESS,
  output logic                     FAST_POR_STATE,
  // Lock lookup
  input  wire fcr_pkg::fcr_sector_t LOCK_QUERY_SECTOR,
  output logic [1:0]               LOCK_QUERY_BITS
);
  import fcr_pkg::*;

  // ----------------------------------------------------------------
  // Link sampling
  // ----------------------------------------------------------------
  logic [1:0]  sclk_sy_r;
  logic [1:0]  cs_sy_r;
  logic [1:0]  mosi_sy_r;
  logic        sclk_q_r;
  logic        cs_q_r;
  logic        sel;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        cs_rise;

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      sclk_sy_r <= 2'h0;
      cs_sy_r   <= 2'h3;
      mosi_sy_r <= 2'h0;
      sclk_q_r  <= 1'b0;
      cs_q_r    <= 1'b1;
    end else begin
      sclk_sy_r <= {sclk_sy_r[0], SPI.sclk};
      cs_sy_r   <= {cs_sy_r[0], SPI.cs_n};
      mosi_sy_r <= {mosi_sy_r[0], SPI.mosi};
      sclk_q_r  <= sclk_sy_r[1];
      cs_q_r    <= cs_sy_r[1];
    end
  end

  assign sel       = ~cs_sy_r[1];
  assign sclk_rise = sclk_sy_r[1] & ~sclk_q_r;
  assign sclk_fall = ~sclk_sy_r[1] & sclk_q_r;
  assign cs_rise   = cs_sy_r[1] & ~cs_q_r;

  // ----------------------------------------------------------------
  // Frame shifter
  // ----------------------------------------------------------------
  logic [6:0]  cnt_r;
  logic [3:0]  bitpos_r;
  logic [39:0] shreg_r;
  fcr_byte_t   op_r;
  fcr_byte_t   rd_lock_r;
  logic [1:0]  lock_mem [NUM_SECTORS];

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      cnt_r     <= 7'h0;
      bitpos_r  <= 4'h0;
      shreg_r   <= 40'h0;
      op_r      <= 8'h0;
      rd_lock_r <= 8'h0;
    end else if (!sel) begin
      cnt_r    <= 7'h0;
      bitpos_r <= 4'h0;
    end else if (sclk_rise) begin
      shreg_r  <= {shreg_r[38:0], mosi_sy_r[1]};
      bitpos_r <= bitpos_r + 4'h1;
      if (cnt_r != 7'h7f) begin
        cnt_r <= cnt_r + 7'h1;
      end
      if (cnt_r == BITS_OPCODE - 7'h1) begin
        op_r <= {shreg_r[6:0], mosi_sy_r[1]};
      end
      if (cnt_r == BITS_LOCK_ADDR - 7'h1) begin
        rd_lock_r <= {6'h0, lock_mem[shreg_r[22:15]]};
      end
    end
  end

  // ----------------------------------------------------------------
  // Instruction acceptance
  // ----------------------------------------------------------------
  logic        wel_r;
  logic        fast_por_r;
  logic        por_done_r;
  logic        nv_busy_r;
  logic [31:0] nv_cnt_r;
  logic [15:0] nv_pend_r;
  logic [15:0] nv_store_r;
  logic        nv_done;
  logic        busy_any;
  logic        acc_write_enable_cmd;
  logic        acc_wrdi;
  logic        acc_clr;
  logic        acc_pes;
  logic        acc_nv;
  logic        acc_vol;
  logic        acc_evol;
  logic        acc_lock;

  function automatic logic is_frame(input fcr_byte_t want, input logic [6:0] len);
    is_frame = (op_r == want) && (cnt_r == len);
  endfunction : is_frame

  assign busy_any = nv_busy_r | ARRAY_BUSY;
  assign acc_write_enable_cmd = cs_rise && is_frame(CMD_WRITE_ENABLE, BITS_OPCODE) && !busy_any;
  assign acc_wrdi = cs_rise && is_frame(CMD_WRITE_DISABLE, BITS_OPCODE) && !busy_any;
  assign acc_clr  = cs_rise && is_frame(CMD_CLEAR_FLAG_STATUS, BITS_OPCODE);
  assign acc_pes  = cs_rise && is_frame(CMD_PE_SUSPEND, BITS_OPCODE);
  assign acc_nv   = cs_rise && is_frame(CMD_WRITE_NV_CONFIG, BITS_NV_WRITE)
                    && wel_r && !busy_any;
  assign acc_vol  = cs_rise && is_frame(CMD_WRITE_VOL_CONFIG, BITS_VOL_WRITE)
                    && (wel_r || fast_por_r) && !busy_any;
  assign acc_evol = cs_rise && is_frame(CMD_WRITE_EVOL_CONFIG, BITS_VOL_WRITE)
                    && (wel_r || fast_por_r) && !busy_any;
  assign acc_lock = cs_rise && is_frame(CMD_WRITE_LOCK, BITS_LOCK_WRITE)
                    && wel_r && !busy_any;
  assign nv_done  = nv_busy_r && (nv_cnt_r == 32'(NV_WRITE_CYCLES - 1));

  // ----------------------------------------------------------------
  // Write-enable latch
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      wel_r <= 1'b0;
    end else if (nv_done) begin
      wel_r <= 1'b0;
    end else if (acc_vol || acc_evol || acc_lock) begin
      wel_r <= 1'b0;
    end else if (acc_write_enable_cmd) begin
      wel_r <= 1'b1;
    end else if (acc_wrdi) begin
      wel_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Power-on capture
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      por_done_r       <= 1'b0;
      fast_por_r       <= 1'b0;
      NV_CONFIG_ACTIVE <= NVCR_RESET;
    end else if (!por_done_r) begin
      por_done_r       <= 1'b1;
      fast_por_r       <= FAST_POR_STRAP;
      NV_CONFIG_ACTIVE <= nv_store_r;
    end else if (acc_write_enable_cmd) begin
      fast_por_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Self-timed nonvolatile write
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      nv_busy_r <= 1'b0;
      nv_cnt_r  <= 32'h0;
      nv_pend_r <= 16'h0;
    end else if (acc_nv) begin
      nv_busy_r <= 1'b1;
      nv_cnt_r  <= 32'h0;
      nv_pend_r <= {shreg_r[7:0], shreg_r[15:8]};
    end else if (nv_done) begin
      nv_busy_r <= 1'b0;
    end else if (nv_busy_r) begin
      nv_cnt_r <= nv_cnt_r + 32'h1;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!NV_INIT_N) begin
      nv_store_r <= NVCR_RESET;
    end else if (nv_done) begin
      nv_store_r <= nv_pend_r;
    end
  end

  // ----------------------------------------------------------------
  // Volatile registers, flags and lock bits
  // ----------------------------------------------------------------
  logic [3:0] err_r;

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      VOL_CONFIG  <= VCR_RESET;
      EVOL_CONFIG <= VECR_RESET;
    end else begin
      if (acc_vol) begin
        VOL_CONFIG <= shreg_r[7:0];
      end
      if (acc_evol) begin
        EVOL_CONFIG <= shreg_r[7:0];
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      err_r <= 4'h0;
    end else begin
      err_r <= (err_r & ~{4{acc_clr}}) | ERR_SET;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      for (int i = 0; i < NUM_SECTORS; i++) begin
        lock_mem[i] <= LOCK_RESET;
      end
    end else if (acc_lock && !lock_mem[shreg_r[31:24]][LOCK_DOWN_BIT]) begin
      lock_mem[shreg_r[31:24]] <= shreg_r[1:0];
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      SUSPEND_REQ     <= 1'b0;
      LOCK_QUERY_BITS <= LOCK_RESET;
    end else begin
      SUSPEND_REQ     <= acc_pes && !nv_busy_r;
      LOCK_QUERY_BITS <= lock_mem[LOCK_QUERY_SECTOR];
    end
  end

  // ----------------------------------------------------------------
  // Read data path
  // ----------------------------------------------------------------
  fcr_byte_t  fsr_byte;
  fcr_byte_t  out_byte;
  logic [6:0] out_start;
  logic       miso_r;

  always_comb begin
    fsr_byte                    = 8'h0;
    fsr_byte[FSR_READY_BIT]     = ~busy_any;
    fsr_byte[FSR_ERASE_ERR_BIT] = err_r[ERR_ERASE];
    fsr_byte[FSR_PROG_ERR_BIT]  = err_r[ERR_PROG];
    fsr_byte[FSR_VPP_ERR_BIT]   = err_r[ERR_VPP];
    fsr_byte[FSR_PROT_ERR_BIT]  = err_r[ERR_PROT];
    out_start                   = BITS_OPCODE;
    out_byte                    = 8'h0;
    case (op_r)
      CMD_READ_FLAG_STATUS: out_byte = fsr_byte;
      CMD_READ_STATUS: begin
        out_byte[ST_WIP_BIT] = busy_any;
        out_byte[ST_WEL_BIT] = wel_r;
      end
      CMD_READ_NV_CONFIG:   out_byte = bitpos_r[3] ? nv_store_r[7:0] : nv_store_r[15:8];
      CMD_READ_VOL_CONFIG:  out_byte = VOL_CONFIG;
      CMD_READ_EVOL_CONFIG: out_byte = EVOL_CONFIG;
      CMD_READ_LOCK: begin
        out_byte  = rd_lock_r;
        out_start = BITS_LOCK_ADDR;
      end
      default: out_byte = 8'h0;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N || !sel) begin
      miso_r <= 1'b0;
    end else if (sclk_fall && cnt_r >= out_start) begin
      miso_r <= out_byte[3'h7 - bitpos_r[2:0]];
    end
  end

  assign SPI.miso           = miso_r;
  assign NV_CONFIG_STORED   = nv_store_r;
  assign WRITE_ENABLE_LATCH = wel_r;
  assign WRITE_IN_PROGRESS  = nv_busy_r;
  assign FAST_POR_STATE     = fast_por_r;

endmodule : fcr_device
`default_nettype wire

/* File: common/fcr_pkg.sv */
`default_nettype none
package fcr_pkg;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef logic [7:0] fcr_byte_t;
  typedef logic [7:0] fcr_sector_t;

  // ----------------------------------------------------------------
  // Instruction codes
  // ----------------------------------------------------------------
  localparam fcr_byte_t CMD_WRITE_ENABLE      = 8'h06;
  localparam fcr_byte_t CMD_WRITE_DISABLE     = 8'h04;
  localparam fcr_byte_t CMD_READ_STATUS       = 8'h05;
  localparam fcr_byte_t CMD_READ_FLAG_STATUS  = 8'h70;
  localparam fcr_byte_t CMD_CLEAR_FLAG_STATUS = 8'h50;
  localparam fcr_byte_t CMD_READ_NV_CONFIG    = 8'hb5;
  localparam fcr_byte_t CMD_WRITE_NV_CONFIG   = 8'hb1;
  localparam fcr_byte_t CMD_READ_LOCK         = 8'he8;
  localparam fcr_byte_t CMD_WRITE_LOCK        = 8'he5;
  localparam fcr_byte_t CMD_PE_SUSPEND        = 8'h75;
  localparam fcr_byte_t CMD_READ_VOL_CONFIG   = 8'h8a;
  localparam fcr_byte_t CMD_WRITE_VOL_CONFIG  = 8'h8b;
  localparam fcr_byte_t CMD_READ_EVOL_CONFIG  = 8'h6a;
  localparam fcr_byte_t CMD_WRITE_EVOL_CONFIG = 8'h6b;

  // ----------------------------------------------------------------
  // Frame lengths in bits, opcode included
  // ----------------------------------------------------------------
  localparam logic [6:0] BITS_OPCODE     = 7'h08;
  localparam logic [6:0] BITS_VOL_WRITE  = 7'h10;
  localparam logic [6:0] BITS_NV_WRITE   = 7'h18;
  localparam logic [6:0] BITS_LOCK_ADDR  = 7'h20;
  localparam logic [6:0] BITS_LOCK_WRITE = 7'h28;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ST_WIP_BIT        = 0;
  localparam int ST_WEL_BIT        = 1;
  localparam int FSR_READY_BIT     = 7;
  localparam int FSR_ERASE_ERR_BIT = 5;
  localparam int FSR_PROG_ERR_BIT  = 4;
  localparam int FSR_VPP_ERR_BIT   = 3;
  localparam int FSR_PROT_ERR_BIT  = 1;
  localparam int ERR_ERASE         = 0;
  localparam int ERR_PROG          = 1;
  localparam int ERR_VPP           = 2;
  localparam int ERR_PROT          = 3;
  localparam int LOCK_DOWN_BIT     = 1;
  localparam fcr_byte_t LOCK_IN_MASK = 8'h03;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] NVCR_RESET = 16'hffff;
  localparam fcr_byte_t   VCR_RESET  = 8'hff;
  localparam fcr_byte_t   VECR_RESET = 8'hff;
  localparam logic [1:0]  LOCK_RESET = 2'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ            = 200;
  localparam int NVCR_WRITE_TIME_US = 1000;
  localparam int NVCR_WRITE_CYCLES  = NVCR_WRITE_TIME_US * CLK_MHZ;
  localparam int SCLK_HALF_CYCLES   = 8;

endpackage : fcr_pkg
`default_nettype wire

/* File: common/fcr_spi_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface fcr_spi_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  modport dev  (input sclk, input cs_n, input mosi, output miso);
  modport host (output sclk, output cs_n, output mosi, input miso);
endinterface : fcr_spi_if
`default_nettype wire

/* File: rtl/fcr_host.sv */
`timescale 1ns/1ps
`default_nettype none
module fcr_host (
  // Clock and reset
  input  wire logic               REF_CLK,
  input  wire logic               RESET_N,
  // Serial link
  fcr_spi_if.host                 SPI,
  // Command request
  input  wire logic               CMD_VALID,
  input  wire fcr_pkg::fcr_byte_t CMD_OPCODE,
  input  wire logic [5:0]         CMD_NBITS,
  input  wire logic [31:0]        CMD_TXD,
  output logic                    CMD_READY,
  // Response
  output logic                    RSP_VALID,
  output logic [31:0]             RSP_DATA
);
  import fcr_pkg::*;

  typedef enum {H_IDLE, H_LOAD, H_SHIFT, H_END, H_GAP} fcr_hstate_e;
  typedef enum {PH_WRITE_ENABLE_CMD, PH_CMD, PH_POLL} fcr_phase_e;

  fcr_hstate_e state_r;
  fcr_phase_e  phase_r;
  fcr_byte_t   op_r;
  fcr_byte_t   load_op;
  logic [5:0]  nbits_r;
  logic [5:0]  load_bits;
  logic [31:0] txd_r;
  logic [39:0] sreg_r;
  logic [6:0]  left_r;
  logic [3:0]  div_r;
  logic        tick;
  logic        sclk_r;
  logic        cs_n_r;
  logic        mosi_r;
  logic [1:0]  miso_sy_r;

  // ----------------------------------------------------------------
  // Framing helpers
  // ----------------------------------------------------------------
  function automatic logic is_write(input fcr_byte_t op);
    is_write = (op == CMD_WRITE_NV_CONFIG) || (op == CMD_WRITE_VOL_CONFIG)
               || (op == CMD_WRITE_EVOL_CONFIG) || (op == CMD_WRITE_LOCK);
  endfunction : is_write

  function automatic logic [5:0] frame_bits(input fcr_byte_t op, input logic [5:0] n);
    case (op)
      CMD_WRITE_NV_CONFIG:   frame_bits = 6'(BITS_NV_WRITE - BITS_OPCODE);
      CMD_WRITE_VOL_CONFIG:  frame_bits = 6'(BITS_VOL_WRITE - BITS_OPCODE);
      CMD_WRITE_EVOL_CONFIG: frame_bits = 6'(BITS_VOL_WRITE - BITS_OPCODE);
      CMD_WRITE_LOCK:        frame_bits = 6'(BITS_LOCK_WRITE - BITS_OPCODE);
      CMD_WRITE_ENABLE, CMD_WRITE_DISABLE,
      CMD_CLEAR_FLAG_STATUS, CMD_PE_SUSPEND: frame_bits = 6'h0;
      default:               frame_bits = n;
    endcase
  endfunction : frame_bits

  always_comb begin
    case (phase_r)
      PH_WRITE_ENABLE_CMD: begin
        load_op   = CMD_WRITE_ENABLE;
        load_bits = 6'h0;
      end
      PH_POLL: begin
        load_op   = CMD_READ_FLAG_STATUS;
        load_bits = 6'h08;
      end
      default: begin
        load_op   = op_r;
        load_bits = nbits_r;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Clock divider and input sampling
  // ----------------------------------------------------------------
  assign tick = (div_r == 4'(SCLK_HALF_CYCLES - 1));

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N || state_r == H_IDLE || state_r == H_LOAD || tick) begin
      div_r <= 4'h0;
    end else begin
      div_r <= div_r + 4'h1;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      miso_sy_r <= 2'h0;
    end else begin
      miso_sy_r <= {miso_sy_r[0], SPI.miso};
    end
  end

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      state_r   <= H_IDLE;
      phase_r   <= PH_CMD;
      op_r      <= 8'h0;
      nbits_r   <= 6'h0;
      txd_r     <= 32'h0;
      sreg_r    <= 40'h0;
      left_r    <= 7'h0;
      sclk_r    <= 1'b0;
      cs_n_r    <= 1'b1;
      mosi_r    <= 1'b0;
      CMD_READY <= 1'b1;
      RSP_VALID <= 1'b0;
      RSP_DATA  <= 32'h0;
    end else begin
      RSP_VALID <= 1'b0;
      case (state_r)
        H_IDLE: if (CMD_VALID) begin
          CMD_READY <= 1'b0;
          op_r      <= CMD_OPCODE;
          nbits_r   <= frame_bits(CMD_OPCODE, CMD_NBITS);
          txd_r     <= CMD_TXD;
          if (CMD_OPCODE == CMD_WRITE_LOCK) begin
            txd_r[7:0] <= CMD_TXD[7:0] & LOCK_IN_MASK;
          end
          phase_r   <= is_write(CMD_OPCODE) ? PH_WRITE_ENABLE_CMD : PH_CMD;
          state_r   <= H_LOAD;
        end
        H_LOAD: begin
          sreg_r  <= {load_op, txd_r};
          left_r  <= BITS_OPCODE + {1'b0, load_bits};
          cs_n_r  <= 1'b0;
          mosi_r  <= load_op[7];
          state_r <= H_SHIFT;
        end
        H_SHIFT: if (tick) begin
          if (!sclk_r) begin
            sclk_r   <= 1'b1;
            RSP_DATA <= {RSP_DATA[30:0], miso_sy_r[1]};
            left_r   <= left_r - 7'h1;
          end else begin
            sclk_r <= 1'b0;
            if (left_r == 7'h0) begin
              state_r <= H_END;
            end else begin
              sreg_r <= {sreg_r[38:0], 1'b0};
              mosi_r <= sreg_r[38];
            end
          end
        end
        H_END: if (tick) begin
          cs_n_r  <= 1'b1;
          state_r <= H_GAP;
        end
        H_GAP: if (tick) begin
          if (phase_r == PH_WRITE_ENABLE_CMD) begin
            phase_r <= PH_CMD;
            state_r <= H_LOAD;
          end else if (phase_r == PH_CMD && op_r == CMD_WRITE_NV_CONFIG) begin
            phase_r <= PH_POLL;
            state_r <= H_LOAD;
          end else if (phase_r == PH_POLL && !RSP_DATA[FSR_READY_BIT]) begin
            state_r <= H_LOAD;
          end else begin
            RSP_VALID <= 1'b1;
            CMD_READY <= 1'b1;
            state_r   <= H_IDLE;
          end
        end
        default: state_r <= H_IDLE;
      endcase
    end
  end

  assign SPI.sclk = sclk_r;
  assign SPI.cs_n = cs_n_r;
  assign SPI.mosi = mosi_r;

endmodule : fcr_host
`default_nettype wire

/* File: testbench/fcr_link_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module fcr_link_asserts (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RESET_N,
  // Serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);
  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  sequence s_low6;
    !sclk [*6];
  endsequence
  sequence s_high7;
    sclk [*7];
  endsequence
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_miso_idle;
    cs_n [*6] |-> !miso;
  endproperty
  property p_sclk_idle;
    cs_n && $past(cs_n) |-> !sclk;
  endproperty
  property p_sclk_high;
    $rose(sclk) |=> s_high7 ##1 !sclk;
  endproperty
  property p_sclk_low;
    $fell(sclk) |=> s_low6;
  endproperty
  property p_mosi_hold;
    sclk |-> $stable(mosi);
  endproperty
  property p_miso_hold;
    sclk |-> $stable(miso);
  endproperty
  property p_cs_rise;
    $rose(cs_n) |-> !sclk ##1 cs_n [*7];
  endproperty
  property p_cs_fall;
    $fell(cs_n) |-> !sclk ##1 s_low6;
  endproperty
  a_miso_idle: assert property (p_miso_idle)
    else $error("miso not low while deselected");
  a_sclk_idle: assert property (p_sclk_idle)
    else $error("sclk not idle low while deselected");
  a_sclk_high: assert property (p_sclk_high)
    else $error("sclk high phase length wrong");
  a_sclk_low: assert property (p_sclk_low)
    else $error("sclk low phase too short");
  a_mosi_hold: assert property (p_mosi_hold)
    else $error("mosi changed while sclk high");
  a_miso_hold: assert property (p_miso_hold)
    else $error("miso changed while sclk high");
  a_cs_rise: assert property (p_cs_rise)
    else $error("chip select rise framing wrong");
  a_cs_fall: assert property (p_cs_fall)
    else $error("chip select fall framing wrong");
endmodule : fcr_link_asserts
`default_nettype wire

/* File: testbench/flash_config_register_commands_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_config_register_commands_tb;
  import fcr_pkg::*;
  localparam int NVC = 50;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        busy = 1'b0;
  logic [3:0]  err_set = 4'h0;
  logic        strap = 1'b0;
  logic        nv_init_n = 1'b0;
  logic        cmd_valid = 1'b0;
  fcr_byte_t   cmd_op = 8'h00;
  logic [5:0]  cmd_nb = 6'h00;
  logic [31:0] cmd_txd = 32'h0;
  fcr_sector_t qsec = 8'h00;
  logic        cmd_ready, rsp_valid, write_enable_latch, write_in_progress_bit, fpor, susp;
  logic [31:0] rsp, r;
  logic [15:0] nv_act, nv_st;
  fcr_byte_t   vcr, evcr;
  logic [1:0]  qbits;
  fcr_byte_t   ldat [3] = '{8'hfd, 8'hfe, 8'h01};
  logic [1:0]  lexp [3] = '{2'h1, 2'h2, 2'h2};
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          wip_cnt = 0;
  int          n_susp = 0;
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (write_in_progress_bit === 1'b1) wip_cnt <= wip_cnt + 1;
  always @(posedge ref_clk) if (susp === 1'b1) n_susp <= n_susp + 1;
  fcr_spi_if u_fcr_spi_if ();
  fcr_device #(.NV_WRITE_CYCLES(NVC)) u_fcr_device (.REF_CLK(ref_clk), .RESET_N(reset_n),
    .SPI(u_fcr_spi_if), .ARRAY_BUSY(busy), .ERR_SET(err_set), .FAST_POR_STRAP(strap),
    .NV_INIT_N(nv_init_n), .SUSPEND_REQ(susp),
    .NV_CONFIG_ACTIVE(nv_act), .NV_CONFIG_STORED(nv_st),
    .VOL_CONFIG(vcr), .EVOL_CONFIG(evcr), .WRITE_ENABLE_LATCH(write_enable_latch), .WRITE_IN_PROGRESS(write_in_progress_bit),
    .FAST_POR_STATE(fpor), .LOCK_QUERY_SECTOR(qsec), .LOCK_QUERY_BITS(qbits));
  fcr_host u_fcr_host (.REF_CLK(ref_clk), .RESET_N(reset_n), .SPI(u_fcr_spi_if),
    .CMD_VALID(cmd_valid), .CMD_OPCODE(cmd_op), .CMD_NBITS(cmd_nb), .CMD_TXD(cmd_txd),
    .CMD_READY(cmd_ready), .RSP_VALID(rsp_valid), .RSP_DATA(rsp));
  fcr_link_asserts u_fcr_link_asserts (.REF_CLK(ref_clk), .RESET_N(reset_n),
    .sclk(u_fcr_spi_if.sclk), .cs_n(u_fcr_spi_if.cs_n), .mosi(u_fcr_spi_if.mosi),
    .miso(u_fcr_spi_if.miso));
  // ----------------------------------------------------------------
  // Expectations and helpers
  // ----------------------------------------------------------------
  function automatic fcr_byte_t exp_flag(input logic [3:0] e, input logic rdy);
    fcr_byte_t f;
    f = 8'h00;
    f[FSR_READY_BIT] = rdy;
    f[FSR_ERASE_ERR_BIT] = e[ERR_ERASE];
    f[FSR_PROG_ERR_BIT] = e[ERR_PROG];
    f[FSR_VPP_ERR_BIT] = e[ERR_VPP];
    f[FSR_PROT_ERR_BIT] = e[ERR_PROT];
    return f;
  endfunction : exp_flag
  task automatic tally_and_finish();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cycles
  task automatic do_reset();
    reset_n = 1'b0;
    cycles(3);
    nv_init_n = 1'b1;
    cycles(1);
    reset_n = 1'b1;
    cycles(3);
  endtask : do_reset
  task automatic run_cmd(input fcr_byte_t op, input logic [5:0] nb, input logic [31:0] txd);
    int i;
    for (i = 0; i < 20000 && cmd_ready !== 1'b1; i++) cycles(1);
    if (i >= 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_nb = nb;
    cmd_txd = txd;
    cycles(1);
    cmd_valid = 1'b0;
    for (i = 0; i < 20000 && rsp_valid !== 1'b1; i++) cycles(1);
    if (i >= 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
    cycles(2);
  endtask : run_cmd
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    r = $urandom(10);
    do_reset();
    chk("vcr", VCR_RESET, vcr);
    chk("evcr", VECR_RESET, evcr);
    chk("wel", 0, write_enable_latch);
    chk("nv_act", NVCR_RESET, nv_act);
    chk("lock", LOCK_RESET, qbits);
    err_set = 4'hf;
    cycles(1);
    err_set = 4'h0;
    run_cmd(CMD_WRITE_ENABLE, 6'h00, 32'h0);
    chk("wel", 1, write_enable_latch);
    run_cmd(CMD_READ_FLAG_STATUS, 6'h10, 32'h0);
    chk("flag", {2{exp_flag(4'hf, 1'b1)}}, rsp[15:0]);
    busy = 1'b1;
    run_cmd(CMD_READ_FLAG_STATUS, 6'h08, 32'h0);
    chk("flag_busy", exp_flag(4'hf, 1'b0), rsp[7:0]);
    run_cmd(CMD_WRITE_VOL_CONFIG, 6'h00, 32'h12000000);
    chk("vcr_busy", VCR_RESET, vcr);
    chk("wel_busy", 1, write_enable_latch);
    busy = 1'b0;
    run_cmd(CMD_CLEAR_FLAG_STATUS, 6'h00, 32'h0);
    chk("wel_clr", 1, write_enable_latch);
    run_cmd(CMD_READ_FLAG_STATUS, 6'h08, 32'h0);
    chk("flag_clr", exp_flag(4'h0, 1'b1), rsp[7:0]);
    run_cmd(CMD_READ_STATUS, 6'h08, 32'h0);
    chk("status", 32'h1 << ST_WEL_BIT, rsp[7:0]);
    run_cmd(CMD_WRITE_DISABLE, 6'h00, 32'h0);
    chk("wel_wrdi", 0, write_enable_latch);
    run_cmd(CMD_PE_SUSPEND, 6'h00, 32'h0);
    chk("susp", 1, n_susp);
    for (int k = 0; k < 4; k++) begin
      r = (k == 0) ? 32'h0 : (k == 3) ? 32'hffffffff : $urandom();
      run_cmd(k[0] ? CMD_WRITE_EVOL_CONFIG : CMD_WRITE_VOL_CONFIG, 6'h00, r);
      chk("cfg", r[31:24], k[0] ? evcr : vcr);
      chk("wel_vol", 0, write_enable_latch);
      run_cmd(k[0] ? CMD_READ_EVOL_CONFIG : CMD_READ_VOL_CONFIG, 6'h10, 32'h0);
      chk("cfg_rd", {2{r[31:24]}}, rsp[15:0]);
    end
    r = $urandom();
    wip_cnt = 0;
    run_cmd(CMD_WRITE_NV_CONFIG, 6'h00, r);
    chk("wip_len", 1, wip_cnt >= NVC && wip_cnt <= NVC + 1);
    chk("nv_st", {r[23:16], r[31:24]}, nv_st);
    chk("wip", 0, write_in_progress_bit);
    chk("ready", 1, rsp[FSR_READY_BIT]);
    chk("wel_nv", 0, write_enable_latch);
    chk("nv_act", NVCR_RESET, nv_act);
    chk("susp_nv", 1, n_susp);
    run_cmd(CMD_READ_NV_CONFIG, 6'h10, 32'h0);
    chk("nv_rd", r[31:16], rsp[15:0]);
    qsec = r[7:0];
    for (int k = 0; k < 3; k++) begin
      run_cmd(CMD_WRITE_LOCK, 6'h00, {qsec, 16'h0, ldat[k]});
      chk("lock", lexp[k], qbits);
    end
    run_cmd(CMD_READ_LOCK, 6'h20, {qsec, 24'h0});
    chk("lock_rd", 8'h02, rsp[7:0]);
    strap = 1'b1;
    do_reset();
    chk("nv_act_por", {r[23:16], r[31:24]}, nv_act);
    chk("fpor", 1, fpor);
    chk("lock_por", LOCK_RESET, qbits);
    run_cmd(CMD_WRITE_ENABLE, 6'h00, 32'h0);
    chk("fpor_write_enable_cmd", 0, fpor);
    tally_and_finish();
  end
endmodule : flash_config_register_commands_tb
`default_nettype wire
